// ===== bus_event_pkg.sv
// Shared constants and types for the bus event sequencer
package bus_event_pkg;
  localparam int GROUPS = 4;
  localparam int GRP_W = 2;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int STAT_W = 16;
  localparam int PROBE_W = 16;
  localparam int CNT_W = 16;
  localparam int COMPS = 8;
  localparam int TERMS = 8;
  localparam int ACTS = 9;
  localparam int SEL_W = 4;

  // Comparator index inside a group
  localparam int CMP_ADDR1 = 0;
  localparam int CMP_ADDR2 = 1;
  localparam int CMP_DATA1 = 2;
  localparam int CMP_DATA2 = 3;
  localparam int CMP_STAT1 = 4;
  localparam int CMP_STAT2 = 5;
  localparam int CMP_PROBE = 6;
  localparam int CMP_LIMIT = 7;

  // Action bit positions
  localparam int ACT_HALT = 0;
  localparam int ACT_DECR = 1;
  localparam int ACT_VJUMP = 2;
  localparam int ACT_STEP = 3;
  localparam int ACT_RELOAD = 4;
  localparam int ACT_PULSE = 5;
  localparam int ACT_CFLIP = 6;
  localparam int ACT_TFLIP = 7;
  localparam int ACT_RECORD = 8;

  // Status word bit positions
  localparam int ST_IRQ_WAIT = 14;
  localparam int ST_AUTOVEC = 13;
  localparam int ST_HALT = 12;
  localparam int ST_IPL_LO = 9;
  localparam int ST_BUS_FAULT = 8;
  localparam int ST_SPACE_LO = 4;
  localparam int ST_MEM_HIT = 2;
  localparam int ST_RW = 1;
  localparam int ST_SIZE = 0;

  // Configuration port layout
  localparam int SEL_TERM_BIT = 3;
  localparam int TERM_USE_LO = 0;
  localparam int TERM_NEG_LO = 8;
  localparam int TERM_ACT_LO = 0;
  localparam int TERM_TGT_LO = 9;
  localparam int TERM_EN_BIT = 11;

  // Reset values
  localparam logic [GRP_W-1:0] GROUP_RST = 2'h0;
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_INSIDE = 2'h1,
    MODE_OUTSIDE = 2'h3,
    MODE_SPAN = 2'h2
  } cmp_mode_t;
endpackage

// ===== event_cmp.sv
// One comparator: masked match or address span test
module event_cmp #(
  parameter int W = 24
) (
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] pattern,
  input wire logic [W-1:0] upper_or_mask,
  input wire bus_event_pkg::cmp_mode_t mode,
  output logic hit
);
  wire masked_hit = ((value ^ pattern) & ~upper_or_mask) == '0;
  wire in_span = (value >= pattern) && (value <= upper_or_mask);
  // Untyped span falls back to the inside test
  assign hit = (mode == bus_event_pkg::MODE_SINGLE) ? masked_hit :
               (mode == bus_event_pkg::MODE_OUTSIDE) ? !in_span : in_span;
endmodule

// ===== term_eval.sv
// Sum-of-products event terms with action collection
module term_eval #(
  parameter int NT = 8,
  parameter int NC = 8,
  parameter int NA = 9
) (
  input wire logic [NC-1:0] hit,
  input wire logic [NT*NC-1:0] use_flat,
  input wire logic [NT*NC-1:0] neg_flat,
  input wire logic [NT-1:0] en,
  input wire logic [NT*NA-1:0] act_flat,
  input wire logic [NT*2-1:0] tgt_flat,
  output logic [NA-1:0] fire,
  output logic [NA-1:0] present,
  output logic [1:0] step_tgt
);
  always_comb begin
    logic prod;
    logic found;
    prod = 1'b0;
    found = 1'b0;
    fire = '0;
    present = '0;
    step_tgt = 2'h0;
    for (int t = 0; t < NT; t++) begin
      // Negation applies per comparator before the product
      prod = en[t] & (&(~use_flat[t*NC +: NC] | (hit ^ neg_flat[t*NC +: NC])));
      if (en[t]) begin
        present = present | act_flat[t*NA +: NA];
      end
      // All products are live at once and their actions are merged
      if (prod) begin
        fire = fire | act_flat[t*NA +: NA];
        if (act_flat[t*NA + bus_event_pkg::ACT_STEP] && !found) begin
          step_tgt = tgt_flat[t*2 +: 2];
          found = 1'b1;
        end
      end
    end
  end
endmodule

// ===== bus_event_sequencer.sv
// Bus cycle event monitor and four-group sequencer
//
// Operation
// - Four independent groups act as sequencer states
// - Eight comparators per group
// - Address: single, inside or outside span
// - Data match with per-bit don't-care mask
// - Status match over processor and emulator bits
// - Probe pattern match with don't-care mask
// - Status carries fault, irq, space, size bits
// - Sample once per bus cycle; trace same
// - Address compare uses traced bus address only
// - Run entry loads group one limit; count decrements
// - Group switch keeps count unless reload
// - Edits while running apply after restart
// - Negation inverts comparator before conjunction
// - Sum of products, AND before OR
// - All statements active; actions all performed
// - Nine actions: halt, count, jump, step, etc
// - Toggle plus count together means count
// - Statements default to group one, one group
// - Monitor off while dynamic trace enabled
// - Emulation entry starts in group one
// - Counter at zero makes limit event true
// - Trigger held across each triggering cycle
// - Without record or trace toggle actions every cycle traced
module bus_event_sequencer (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic run_mode,
  input wire logic dyn_trace_en,
  input wire logic break_enable,
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_group,
  input wire logic [3:0] cfg_sel,
  input wire logic [1:0] cfg_mode,
  input wire logic [23:0] cfg_value,
  input wire logic [23:0] cfg_aux,
  input wire logic cycle_end,
  input wire logic [23:0] bus_addr,
  input wire logic [15:0] bus_data,
  input wire logic bus_fault_flag,
  input wire logic irq_waiting_flag,
  input wire logic auto_vector_flag,
  input wire logic [2:0] irq_level,
  input wire logic [2:0] space_code,
  input wire logic emulation_memory_hit,
  input wire logic read_write,
  input wire logic eight_bit_access,
  input wire logic [15:0] probe_in,
  output logic halt_req,
  output logic vector_jump_req,
  output logic pulse_out,
  output logic trace_write,
  output logic [23:0] trace_addr,
  output logic [15:0] trace_data,
  output logic [15:0] trace_status,
  output logic [15:0] trace_probe,
  output logic [1:0] active_group,
  output logic limit_reached
);
  localparam int AW = bus_event_pkg::ADDR_W, CW = bus_event_pkg::CNT_W, NG = bus_event_pkg::GROUPS;
  localparam int NC = bus_event_pkg::COMPS, NT = bus_event_pkg::TERMS, NA = bus_event_pkg::ACTS;
  localparam int PW = AW + 3 * 16 + 1;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus cycle sampling
  logic [15:0] status_raw;
  logic [PW-1:0] pin_raw, pin_s1_r, pin_s2_r;
  logic strobe_s3_r, smp_vld_r;
  logic [23:0] smp_addr_r;
  logic [15:0] smp_data_r, smp_stat_r, smp_probe_r;

  // Status word assembled from processor and emulator bits
  always_comb begin
    status_raw = 16'h0000;
    status_raw[bus_event_pkg::ST_IRQ_WAIT] = irq_waiting_flag;
    status_raw[bus_event_pkg::ST_AUTOVEC] = auto_vector_flag;
    status_raw[bus_event_pkg::ST_HALT] = halt_req;
    status_raw[bus_event_pkg::ST_IPL_LO +: 3] = irq_level;
    status_raw[bus_event_pkg::ST_BUS_FAULT] = bus_fault_flag;
    status_raw[bus_event_pkg::ST_SPACE_LO +: 3] = space_code;
    status_raw[bus_event_pkg::ST_MEM_HIT] = emulation_memory_hit;
    status_raw[bus_event_pkg::ST_RW] = read_write;
    status_raw[bus_event_pkg::ST_SIZE] = eight_bit_access;
  end

  // Only the address the processor drives onto the bus is watched
  assign pin_raw = {cycle_end, bus_addr, bus_data, status_raw, probe_in};

  wire strobe_s2 = pin_s2_r[PW-1];
  wire cyc_done = strobe_s2 & ~strobe_s3_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      strobe_s3_r <= 1'b0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      strobe_s3_r <= strobe_s2;
    end
  end

  // One snapshot per bus cycle feeds both matching and trace
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      smp_addr_r <= '0;
      smp_data_r <= '0;
      smp_stat_r <= '0;
      smp_probe_r <= '0;
      smp_vld_r <= 1'b0;
    end else begin
      smp_vld_r <= cyc_done;
      if (cyc_done) begin
        {smp_addr_r, smp_data_r, smp_stat_r, smp_probe_r} <= pin_s2_r[PW-2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Staged and active configuration
  logic [AW-1:0] stg_lo [NG][NC], stg_hi [NG][NC], act_lo [NG][NC], act_hi [NG][NC];
  logic [1:0] stg_mode [NG][NC], act_mode [NG][NC];
  logic [15:0] stg_term [NG][NT], act_term [NG][NT];
  logic [11:0] stg_tact [NG][NT], act_tact [NG][NT];
  logic run_r;

  wire run_rise = run_mode & ~run_r;
  wire term_wr = cfg_wr & cfg_sel[bus_event_pkg::SEL_TERM_BIT];
  wire [2:0] cfg_idx = cfg_sel[2:0];

  // Edits always land in staging; group one is index zero by default
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stg_lo <= '{default: '0};
      stg_hi <= '{default: '0};
      stg_mode <= '{default: '0};
      stg_term <= '{default: '0};
      stg_tact <= '{default: '0};
    end else if (term_wr) begin
      stg_term[cfg_group][cfg_idx] <= cfg_value[15:0];
      stg_tact[cfg_group][cfg_idx] <= cfg_aux[11:0];
    end else if (cfg_wr) begin
      stg_lo[cfg_group][cfg_idx] <= cfg_value;
      stg_hi[cfg_group][cfg_idx] <= cfg_aux;
      stg_mode[cfg_group][cfg_idx] <= cfg_mode;
    end
  end

  // Active copy is taken only at run entry
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      act_lo <= '{default: '0};
      act_hi <= '{default: '0};
      act_mode <= '{default: '0};
      act_term <= '{default: '0};
      act_tact <= '{default: '0};
    end else if (run_rise) begin
      act_lo <= stg_lo;
      act_hi <= stg_hi;
      act_mode <= stg_mode;
      act_term <= stg_term;
      act_tact <= stg_tact;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparators and event terms of the current group
  logic [1:0] group_r, step_tgt;
  logic [CW-1:0] count_r;
  wire [NC-1:0] hit;
  logic [AW-1:0] cmp_val [NC-1];
  logic [NT*NC-1:0] use_flat, neg_flat;
  logic [NT-1:0] term_en;
  logic [NT*NA-1:0] act_flat;
  logic [NT*2-1:0] tgt_flat;
  logic [NA-1:0] fire, present;

  assign cmp_val[bus_event_pkg::CMP_ADDR1] = smp_addr_r;
  assign cmp_val[bus_event_pkg::CMP_ADDR2] = smp_addr_r;
  assign cmp_val[bus_event_pkg::CMP_DATA1] = {8'h00, smp_data_r};
  assign cmp_val[bus_event_pkg::CMP_DATA2] = {8'h00, smp_data_r};
  assign cmp_val[bus_event_pkg::CMP_STAT1] = {8'h00, smp_stat_r};
  assign cmp_val[bus_event_pkg::CMP_STAT2] = {8'h00, smp_stat_r};
  assign cmp_val[bus_event_pkg::CMP_PROBE] = {8'h00, smp_probe_r};

  for (genvar c = 0; c < NC - 1; c++) begin : g_cmp
    localparam bit IS_ADDR = (c <= bus_event_pkg::CMP_ADDR2);
    // Narrow comparators ignore the unused upper bits and never use spans
    wire [AW-1:0] pat = IS_ADDR ? act_lo[group_r][c] : {8'h00, act_lo[group_r][c][15:0]};
    wire [AW-1:0] upm = IS_ADDR ? act_hi[group_r][c] : {8'hff, act_hi[group_r][c][15:0]};
    wire [1:0] md = IS_ADDR ? act_mode[group_r][c] : 2'h0;
    event_cmp #(
      .W(AW)
    ) u_cmp (
      .value(cmp_val[c]),
      .pattern(pat),
      .upper_or_mask(upm),
      .mode(bus_event_pkg::cmp_mode_t'(md)),
      .hit(hit[c])
    );
  end

  assign hit[bus_event_pkg::CMP_LIMIT] = (count_r == bus_event_pkg::COUNT_RST);

  always_comb begin
    for (int t = 0; t < NT; t++) begin
      use_flat[t*NC +: NC] = act_term[group_r][t][bus_event_pkg::TERM_USE_LO +: NC];
      neg_flat[t*NC +: NC] = act_term[group_r][t][bus_event_pkg::TERM_NEG_LO +: NC];
      act_flat[t*NA +: NA] = act_tact[group_r][t][bus_event_pkg::TERM_ACT_LO +: NA];
      tgt_flat[t*2 +: 2] = act_tact[group_r][t][bus_event_pkg::TERM_TGT_LO +: 2];
      term_en[t] = act_tact[group_r][t][bus_event_pkg::TERM_EN_BIT];
    end
  end

  term_eval #(
    .NT(NT),
    .NC(NC),
    .NA(NA)
  ) u_terms (
    .hit(hit),
    .use_flat(use_flat),
    .neg_flat(neg_flat),
    .en(term_en),
    .act_flat(act_flat),
    .tgt_flat(tgt_flat),
    .fire(fire),
    .present(present),
    .step_tgt(step_tgt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Actions, counter and group sequencing
  logic count_on_r, trace_on_r;
  logic [1:0] group_nxt;
  logic [CW-1:0] count_nxt;

  wire enabled = run_r & ~dyn_trace_en;
  wire eval = smp_vld_r & enabled;
  wire do_step = eval & fire[bus_event_pkg::ACT_STEP];
  wire do_reload = eval & fire[bus_event_pkg::ACT_RELOAD];
  // A toggle that meets a plain count in the same event counts instead
  wire cflip_eff = fire[bus_event_pkg::ACT_CFLIP] & ~fire[bus_event_pkg::ACT_DECR];
  wire do_decr = eval & (fire[bus_event_pkg::ACT_DECR] | (fire[bus_event_pkg::ACT_CFLIP] & ~cflip_eff) |
                         count_on_r);
  wire trace_gated = present[bus_event_pkg::ACT_RECORD] | present[bus_event_pkg::ACT_TFLIP];
  wire do_record = eval & (~trace_gated | fire[bus_event_pkg::ACT_RECORD] | trace_on_r);

  assign group_nxt = run_rise ? bus_event_pkg::GROUP_RST : (do_step ? step_tgt : group_r);

  always_comb begin
    count_nxt = count_r;
    if (run_rise) begin
      count_nxt = stg_lo[0][bus_event_pkg::CMP_LIMIT][CW-1:0];
    end else if (do_reload) begin
      count_nxt = act_lo[group_nxt][bus_event_pkg::CMP_LIMIT][CW-1:0];
    end else if (do_decr && count_r != bus_event_pkg::COUNT_RST) begin
      count_nxt = count_r - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      run_r <= 1'b0;
      group_r <= bus_event_pkg::GROUP_RST;
      count_r <= bus_event_pkg::COUNT_RST;
    end else begin
      run_r <= run_mode;
      group_r <= group_nxt;
      count_r <= count_nxt;
    end
  end

  // Toggle states restart off at run entry and on every group change
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count_on_r <= 1'b0;
      trace_on_r <= 1'b0;
    end else if (run_rise || do_step) begin
      count_on_r <= 1'b0;
      trace_on_r <= 1'b0;
    end else if (eval) begin
      count_on_r <= count_on_r ^ cflip_eff;
      trace_on_r <= trace_on_r ^ fire[bus_event_pkg::ACT_TFLIP];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      halt_req <= 1'b0;
      vector_jump_req <= 1'b0;
      pulse_out <= 1'b0;
      trace_write <= 1'b0;
      trace_addr <= '0;
      trace_data <= '0;
      trace_status <= '0;
      trace_probe <= '0;
      active_group <= bus_event_pkg::GROUP_RST;
      limit_reached <= 1'b0;
    end else begin
      halt_req <= eval & fire[bus_event_pkg::ACT_HALT] & break_enable;
      vector_jump_req <= eval & fire[bus_event_pkg::ACT_VJUMP];
      if (!enabled) begin
        pulse_out <= 1'b0;
      end else if (smp_vld_r) begin
        pulse_out <= fire[bus_event_pkg::ACT_PULSE];
      end
      trace_write <= do_record;
      if (do_record) begin
        trace_addr <= smp_addr_r;
        trace_data <= smp_data_r;
        trace_status <= smp_stat_r;
        trace_probe <= smp_probe_r;
      end
      active_group <= group_nxt;
      limit_reached <= (count_nxt == bus_event_pkg::COUNT_RST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_group_start;
    @(posedge ref_clk) disable iff (!nrst) run_rise |=> (group_r == 2'h0) && (active_group == 2'h0);
  endproperty
  a_group_start: assert property (p_group_start) else $error("run entry did not select group one");
  property p_count_load;
    @(posedge ref_clk) disable iff (!nrst)
      run_rise |=> count_r == $past(stg_lo[0][bus_event_pkg::CMP_LIMIT][CW-1:0]);
  endproperty
  a_count_load: assert property (p_count_load) else $error("counter not loaded at run entry");
  property p_decrement;
    @(posedge ref_clk) disable iff (!nrst)
      (do_decr && !do_reload && !run_rise && count_r != 16'h0000) |=> count_r == $past(count_r) - 16'h0001;
  endproperty
  a_decrement: assert property (p_decrement) else $error("count action did not decrement");
  property p_hold_zero;
    @(posedge ref_clk) disable iff (!nrst)
      (count_r == 16'h0000 && !do_reload && !run_rise) |=> count_r == 16'h0000 && limit_reached;
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("counter wrapped below zero");
  property p_keep_on_step;
    @(posedge ref_clk) disable iff (!nrst)
      (do_step && !do_reload && !do_decr && !run_rise) |=> $stable(count_r) && group_r == $past(step_tgt);
  endproperty
  a_keep_on_step: assert property (p_keep_on_step) else $error("group switch disturbed counter");
  property p_halt;
    @(posedge ref_clk) disable iff (!nrst)
      (eval && fire[bus_event_pkg::ACT_HALT] && break_enable) |=> halt_req ##1 !halt_req || smp_vld_r;
  endproperty
  a_halt: assert property (p_halt) else $error("halt action missing");
  property p_dyn_off;
    @(posedge ref_clk) disable iff (!nrst) dyn_trace_en |=> !halt_req && !trace_write && !vector_jump_req;
  endproperty
  a_dyn_off: assert property (p_dyn_off) else $error("monitor acted during dynamic trace");
  property p_pulse;
    @(posedge ref_clk) disable iff (!nrst)
      (eval && fire[bus_event_pkg::ACT_PULSE]) || (pulse_out && enabled && !smp_vld_r) |=> pulse_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("trigger dropped inside its bus cycle");
  property p_trace_all;
    @(posedge ref_clk) disable iff (!nrst) (eval && !trace_gated) |=> trace_write && trace_addr == $past(smp_addr_r);
  endproperty
  a_trace_all: assert property (p_trace_all) else $error("ungated cycle not traced");
endmodule

// ===== cpu_bus_model.sv
// Processor bus model that produces one sampled bus cycle per call
module cpu_bus_model (
  input wire logic ref_clk,
  output logic cycle_end,
  output logic [23:0] bus_addr,
  output logic [15:0] bus_data,
  output logic bus_fault_flag,
  output logic irq_waiting_flag,
  output logic auto_vector_flag,
  output logic [2:0] irq_level,
  output logic [2:0] space_code,
  output logic emulation_memory_hit,
  output logic read_write,
  output logic eight_bit_access,
  output logic [15:0] probe_in
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////
  initial begin
    cycle_end = 1'b0;
    bus_addr = 24'h00_0000;
    bus_data = 16'h0000;
    probe_in = 16'h0000;
    bus_fault_flag = 1'b0;
    irq_waiting_flag = 1'b0;
    auto_vector_flag = 1'b0;
    irq_level = 3'h0;
    space_code = 3'h0;
    emulation_memory_hit = 1'b0;
    read_write = 1'b1;
    eight_bit_access = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////
  // Lines settle before the strobe, hold after it, then turn over
  task cyc(input logic [23:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_data <= d;
    probe_in <= d;
    repeat (3) @(posedge ref_clk);
    cycle_end <= 1'b1;
    repeat (4) @(posedge ref_clk);
    cycle_end <= 1'b0;
    bus_addr <= ~a;
    bus_data <= ~d;
    probe_in <= ~d;
    repeat (2) @(posedge ref_clk);
  endtask
endmodule

// ===== bus_event_sequencer_tb.sv
// Self-checking testbench of the bus event sequencer
module bus_event_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, nrst = 1'b0, run_mode = 1'b0, dyn_trace_en = 1'b0, break_enable = 1'b0;
  logic cfg_wr = 1'b0;
  logic [1:0] cfg_group = 2'h0, cfg_mode = 2'h0;
  logic [3:0] cfg_sel = 4'h0;
  logic [23:0] cfg_value = 24'h00_0000, cfg_aux = 24'h00_0000;
  logic cycle_end, bus_fault_flag, irq_waiting_flag, auto_vector_flag, emulation_memory_hit;
  logic read_write, eight_bit_access, halt_req, vector_jump_req, pulse_out, trace_write, limit_reached;
  logic [23:0] bus_addr, trace_addr;
  logic [15:0] bus_data, probe_in, trace_data, trace_status, trace_probe;
  logic [2:0] irq_level, space_code;
  logic [1:0] active_group;
  int n_fail = 0, samples_checked = 0, n_halt = 0, n_trace = 0, n_jump = 0;
  ////////////////////////////////////////////////////////////////////
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (halt_req === 1'b1) n_halt++;
    if (trace_write === 1'b1) n_trace++;
    if (vector_jump_req === 1'b1) n_jump++;
  end
  bus_event_sequencer i_bus_event_sequencer (.ref_clk(ref_clk), .nrst(nrst), .run_mode(run_mode),
    .dyn_trace_en(dyn_trace_en), .break_enable(break_enable), .cfg_wr(cfg_wr), .cfg_group(cfg_group),
    .cfg_sel(cfg_sel), .cfg_mode(cfg_mode), .cfg_value(cfg_value), .cfg_aux(cfg_aux),
    .cycle_end(cycle_end), .bus_addr(bus_addr), .bus_data(bus_data), .bus_fault_flag(bus_fault_flag),
    .irq_waiting_flag(irq_waiting_flag), .auto_vector_flag(auto_vector_flag), .irq_level(irq_level),
    .space_code(space_code), .emulation_memory_hit(emulation_memory_hit), .read_write(read_write),
    .eight_bit_access(eight_bit_access), .probe_in(probe_in), .halt_req(halt_req),
    .vector_jump_req(vector_jump_req), .pulse_out(pulse_out), .trace_write(trace_write),
    .trace_addr(trace_addr), .trace_data(trace_data), .trace_status(trace_status),
    .trace_probe(trace_probe), .active_group(active_group), .limit_reached(limit_reached));
  cpu_bus_model i_cpu_bus_model (.ref_clk(ref_clk), .cycle_end(cycle_end), .bus_addr(bus_addr),
    .bus_data(bus_data), .bus_fault_flag(bus_fault_flag), .irq_waiting_flag(irq_waiting_flag),
    .auto_vector_flag(auto_vector_flag), .irq_level(irq_level), .space_code(space_code),
    .emulation_memory_hit(emulation_memory_hit), .read_write(read_write),
    .eight_bit_access(eight_bit_access), .probe_in(probe_in));
  ////////////////////////////////////////////////////////////////////
  task chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cfg(input logic [1:0] g, input logic [3:0] s, input logic [1:0] m, input logic [23:0] v,
    input logic [23:0] a);
    @(posedge ref_clk);
    cfg_wr <= 1'b1;
    cfg_group <= g;
    cfg_sel <= s;
    cfg_mode <= m;
    cfg_value <= v;
    cfg_aux <= a;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
  endtask
  task run(input logic b);
    @(posedge ref_clk);
    run_mode <= 1'b0;
    break_enable <= b;
    @(posedge ref_clk);
    run_mode <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask
  task rst;
    @(posedge ref_clk);
    nrst <= 1'b0;
    run_mode <= 1'b0;
    dyn_trace_en <= 1'b0;
    @(posedge ref_clk);
    nrst <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////
  task t_match;
    int h;
    rst;
    cfg(2'h0, 4'h0, 2'h0, 24'h00_1234, 24'h00_0000);
    cfg(2'h0, 4'h8, 2'h0, 24'h00_0001, 24'h00_0821);
    run(1'b1);
    h = n_halt;
    i_cpu_bus_model.cyc(24'h00_1234, 16'h0000);
    chk(24'(n_halt - h), 24'h00_0001);
    chk(pulse_out, 1'b1);
    i_cpu_bus_model.cyc(24'h00_1235, 16'h0000);
    chk(pulse_out, 1'b0);
    chk(24'(n_halt - h), 24'h00_0001);
    $display("test match done");
  endtask
  task t_span;
    rst;
    cfg(2'h0, 4'h1, 2'h1, 24'h00_0100, 24'h00_01FF);
    cfg(2'h0, 4'h8, 2'h0, 24'h00_0202, 24'h00_0820);
    run(1'b0);
    i_cpu_bus_model.cyc(24'h00_0150, 16'h0000);
    chk(pulse_out, 1'b0);
    i_cpu_bus_model.cyc(24'h00_0250, 16'h0000);
    chk(pulse_out, 1'b1);
    cfg(2'h0, 4'h1, 2'h3, 24'h00_0100, 24'h00_01FF);
    cfg(2'h0, 4'h8, 2'h0, 24'h00_0002, 24'h00_0820);
    run(1'b0);
    i_cpu_bus_model.cyc(24'h00_0150, 16'h0000);
    chk(pulse_out, 1'b0);
    i_cpu_bus_model.cyc(24'h00_0250, 16'h0000);
    chk(pulse_out, 1'b1);
    $display("test span done");
  endtask
  task t_count;
    rst;
    cfg(2'h0, 4'h7, 2'h0, 24'h00_0002, 24'h00_0000);
    cfg(2'h0, 4'h8, 2'h0, 24'h00_0000, 24'h00_0802);
    run(1'b0);
    chk(limit_reached, 1'b0);
    for (int i = 0; i < 3; i++) begin
      i_cpu_bus_model.cyc(24'h00_0010, 16'h0000);
      chk(limit_reached, i > 0);
    end
    $display("test count done");
  endtask
  task t_group;
    rst;
    cfg(2'h0, 4'h7, 2'h0, 24'h00_0003, 24'h00_0000);
    cfg(2'h1, 4'h7, 2'h0, 24'h00_0000, 24'h00_0000);
    cfg(2'h0, 4'h8, 2'h0, 24'h00_0000, 24'h00_0A08);
    run(1'b0);
    cfg(2'h0, 4'h8, 2'h0, 24'h00_0000, 24'h00_0A18);
    i_cpu_bus_model.cyc(24'h00_0020, 16'h0000);
    chk(active_group, 2'h1);
    chk(limit_reached, 1'b0);
    run(1'b0);
    chk(active_group, 2'h0);
    i_cpu_bus_model.cyc(24'h00_0020, 16'h0000);
    chk(active_group, 2'h1);
    chk(limit_reached, 1'b1);
    $display("test group done");
  endtask
  task t_trace;
    int t;
    rst;
    run(1'b0);
    t = n_trace;
    i_cpu_bus_model.cyc(24'hAB_CDEF, 16'h5A5A);
    chk(24'(n_trace - t), 24'h00_0001);
    chk(trace_addr, 24'hAB_CDEF);
    chk(trace_data, 16'h5A5A);
    chk(trace_probe, 16'h5A5A);
    chk(trace_status, 16'h0002);
    @(posedge ref_clk);
    dyn_trace_en <= 1'b1;
    i_cpu_bus_model.cyc(24'h00_0001, 16'h0001);
    chk(24'(n_trace - t), 24'h00_0001);
    $display("test trace done");
  endtask
  task t_fields;
    int t;
    int j;
    rst;
    cfg(2'h0, 4'h0, 2'h2, 24'h00_0100, 24'h00_01FF);
    cfg(2'h0, 4'h2, 2'h0, 24'h00_02F3, 24'h00_F00F);
    cfg(2'h0, 4'h4, 2'h0, 24'h00_0002, 24'h00_FFFD);
    cfg(2'h0, 4'h6, 2'h0, 24'h00_02F3, 24'h00_F0F0);
    cfg(2'h0, 4'h8, 2'h0, 24'h00_0055, 24'h00_0904);
    run(1'b0);
    t = n_trace;
    j = n_jump;
    i_cpu_bus_model.cyc(24'h00_0180, 16'h12F3);
    chk(24'(n_jump - j), 24'h00_0001);
    chk(24'(n_trace - t), 24'h00_0001);
    i_cpu_bus_model.cyc(24'h00_0180, 16'h02F4);
    chk(24'(n_trace - t), 24'h00_0001);
    i_cpu_bus_model.cyc(24'h00_0180, 16'h12B3);
    chk(24'(n_trace - t), 24'h00_0001);
    i_cpu_bus_model.cyc(24'h00_0250, 16'h12F3);
    chk(24'(n_trace - t), 24'h00_0001);
    chk(trace_addr, 24'h00_0180);
    chk(24'(n_jump - j), 24'h00_0001);
    $display("test fields done");
  endtask
  ////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    t_match;
    t_span;
    t_count;
    t_group;
    t_trace;
    t_fields;
    stop_test;
  end
  // Tests need under 400 cycles; allow ten times that
  initial begin
    repeat (4000) @(posedge ref_clk);
    n_fail++;
    stop_test;
  end
endmodule
